// ---- rtl/tdi_bank.sv ----
// eight-channel threshold input bank with AHB-Lite register slave
// assumes voltage samples in millivolts arrive from logic on mclk_in
`timescale 1ns/1ps
`include "tdi_consts.svh"
module tdi_bank #(
  parameter int unsigned SCAN_CYCLES = `TDI_SCAN_CYCLES
) (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          hsel_in,
  input  wire logic [31:0]                   haddr_in,
  input  wire logic [1:0]                    htrans_in,
  input  wire logic                          hwrite_in,
  input  wire logic [2:0]                    hsize_in,
  input  wire logic [31:0]                   hwdata_in,
  input  wire logic                          hready_in,
  input  wire tdi_pkg::tdi_mv_t [7:0]        volt_in,
  output logic                               hreadyout_out,
  output logic                               hresp_out,
  output tdi_pkg::tdi_word_t                 hrdata_out,
  output logic [7:0]                         state_out
);
  import tdi_pkg::*;

  // ========================================================================
  // scan pulse, one clock every 5 ms
  logic [31:0] scan_cnt_q;
  logic        scan_q;
  wire         scan_wrap = scan_cnt_q >= (SCAN_CYCLES - 32'd1);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scan_cnt_q <= 32'h00000000;
      scan_q     <= 1'b0;
    end else begin
      scan_cnt_q <= scan_wrap ? 32'h00000000 : scan_cnt_q + 32'h00000001;
      scan_q     <= scan_wrap;
    end
  end

  // ========================================================================
  // bus address phase
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  wire         accept  = hsel_in && htrans_in[1] && hready_in;
  wire  [11:0] a_ofs   = haddr_in[11:0];
  wire         a_ch    = (a_ofs & 12'hF00) == `TDI_CH_REGION;
  wire  [2:0]  a_idx   = a_ofs[7:5];
  wire  [2:0]  a_reg   = a_ofs[4:2];
  wire         w_ch    = (wr_addr_q & 12'hF00) == `TDI_CH_REGION;
  wire  [2:0]  w_idx   = wr_addr_q[7:5];
  wire  [2:0]  w_reg   = wr_addr_q[4:2];

  // ========================================================================
  // per-channel settings, each held apart from the others
  logic [7:0]       base_q;
  logic [7:0]       sense_q;
  logic [7:0]       ac_q;
  tdi_dv_t [7:0]    pickup_q;
  tdi_dv_t [7:0]    dropout_q;
  tdi_ms_t [7:0]    rise_q;
  tdi_ms_t [7:0]    fall_q;
  logic [7:0]       clear_q;
  tdi_word_t [7:0]  tally;
  logic [7:0]       chan_state;

  // out-of-range writes are clamped rather than refused
  function automatic tdi_dv_t clamp_dv(input logic [31:0] v, input tdi_dv_t lo);
    tdi_dv_t r;
    r = lo;
    if (v > 32'(`TDI_LEVEL_MAX)) begin
      r = `TDI_LEVEL_MAX;
    end else if (v > 32'(lo)) begin
      r = v[15:0];
    end
    return r;
  endfunction

  function automatic tdi_ms_t clamp_ms(input logic [31:0] v);
    tdi_ms_t r;
    r = (v > 32'(`TDI_DELAY_MAX)) ? `TDI_DELAY_MAX : v[20:0];
    return r;
  endfunction

  wire base_wr = wr_pend_q && (wr_addr_q == `TDI_OFS_BASE);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_q <= 8'h00;
    end else if (base_wr) begin
      base_q <= hwdata_in[7:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      wire sel = wr_pend_q && w_ch && (w_idx == 3'(g));

      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          sense_q[g]   <= 1'b0;
          ac_q[g]      <= 1'b0;
          pickup_q[g]  <= `TDI_PICKUP_RST;
          dropout_q[g] <= `TDI_DROPOUT_RST;
          rise_q[g]    <= 21'h000000;
          fall_q[g]    <= 21'h000000;
          clear_q[g]   <= 1'b0;
        end else begin
          clear_q[g] <= sel && (w_reg == `TDI_REG_CLEAR)
                        && (hwdata_in == `TDI_CLEAR_CMD);
          if (sel) begin
            unique case (w_reg)
              `TDI_REG_CFG: begin
                sense_q[g] <= hwdata_in[`TDI_CFG_SENSE_BIT];
                ac_q[g]    <= hwdata_in[`TDI_CFG_AC_BIT];
              end
              `TDI_REG_PICKUP:  pickup_q[g]  <= clamp_dv(hwdata_in, `TDI_PICKUP_MIN);
              `TDI_REG_DROPOUT: dropout_q[g] <= clamp_dv(hwdata_in, `TDI_DROPOUT_MIN);
              `TDI_REG_RISE:    rise_q[g]    <= clamp_ms(hwdata_in);
              `TDI_REG_FALL:    fall_q[g]    <= clamp_ms(hwdata_in);
              default: begin
              end
            endcase
          end
        end
      end

      tdi_channel u_ch (
        .mclk_in    (mclk_in),
        .rst_n_in   (rst_n_in),
        .scan_in    (scan_q),
        .volt_in    (volt_in[g]),
        .sense_in   (sense_q[g]),
        .ac_in      (ac_q[g]),
        .pickup_in  (pickup_q[g]),
        .dropout_in (dropout_q[g]),
        .rise_in    (rise_q[g]),
        .fall_in    (fall_q[g]),
        .clear_in   (clear_q[g]),
        .state_out  (chan_state[g]),
        .tally_out  (tally[g])
      );
    end
  endgenerate

  assign state_out = chan_state;

  // ========================================================================
  // read mux, decoded in the address phase
  wire [7:0] ch_num = base_q + 8'(a_idx) + 8'h01;
  tdi_word_t ch_rd;
  tdi_word_t rd_d;

  always_comb begin
    ch_rd = 32'h00000000;
    unique case (a_reg)
      `TDI_REG_CFG: begin
        ch_rd[`TDI_CFG_SENSE_BIT] = sense_q[a_idx];
        ch_rd[`TDI_CFG_AC_BIT]    = ac_q[a_idx];
        ch_rd[15:8]               = ch_num;
      end
      `TDI_REG_PICKUP:  ch_rd = 32'(pickup_q[a_idx]);
      `TDI_REG_DROPOUT: ch_rd = 32'(dropout_q[a_idx]);
      `TDI_REG_RISE:    ch_rd = 32'(rise_q[a_idx]);
      `TDI_REG_FALL:    ch_rd = 32'(fall_q[a_idx]);
      `TDI_REG_TALLY:   ch_rd = tally[a_idx];
      `TDI_REG_CLEAR:   ch_rd = 32'h00000000;
      `TDI_REG_VOLT:    ch_rd = 32'(volt_in[a_idx]);
    endcase
  end

  assign rd_d = a_ch                        ? ch_rd :
                (a_ofs == `TDI_OFS_BASE)    ? 32'(base_q) :
                (a_ofs == `TDI_OFS_STATE)   ? 32'(chan_state) : 32'h00000000;

  // ========================================================================
  // bus response: zero wait, always okay
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_q     <= 1'b0;
      wr_addr_q     <= 12'h000;
      hrdata_out    <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend_q     <= accept && hwrite_in;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (accept) begin
        wr_addr_q <= {a_ofs[11:2], 2'b00};
        if (!hwrite_in) begin
          hrdata_out <= rd_d;
        end
      end
    end
  end
endmodule

// ---- rtl/tdi_consts.svh ----
// offsets, reset values, ranges and timing counts of the threshold input bank
// assumes a 200 MHz system clock and word-aligned AHB-Lite register access
// ==========================================================================
// Operation
// - eight isolated inputs, two groups of four
// - channel number is preceding count plus one..eight
// - every channel sampled once per 5 ms scan
// - per-channel pickup level 16.0-200.0 V, default 88
// - per-channel dropout level 10.0-200.0 V, default 60
// - normal sense: above pickup on, below dropout off
// - inverted sense: above pickup off, below dropout on
// - rise qualify delay 0-1800 s, ms steps
// - fall qualify delay 0-1800 s, ms steps
// - alternating mode adds 30 ms before deactivation
// - alternating mode dropout equals ten percent pickup
// - 32-bit tally counts each rising status change
// - writing one to clear command zeroes tally
// - live voltage readout 0-275 V, millivolt steps
// - all channel settings independent of each other
`ifndef TDI_CONSTS_SVH
`define TDI_CONSTS_SVH

// ==========================================================================
// timing
`define TDI_CLK_MHZ        200
`define TDI_SCAN_MS        5
`define TDI_SCAN_CYCLES    (`TDI_SCAN_MS * 1000 * `TDI_CLK_MHZ)
`define TDI_SCAN_STEP_MS   22'h000005
`define TDI_AC_EXTRA_MS    22'h00001E

// ==========================================================================
// register map, byte addresses
`define TDI_OFS_BASE       12'h000
`define TDI_OFS_STATE      12'h004
`define TDI_CH_REGION      12'h100
`define TDI_CH_STRIDE      12'h020
`define TDI_REG_CFG        3'h0
`define TDI_REG_PICKUP     3'h1
`define TDI_REG_DROPOUT    3'h2
`define TDI_REG_RISE       3'h3
`define TDI_REG_FALL       3'h4
`define TDI_REG_TALLY      3'h5
`define TDI_REG_CLEAR      3'h6
`define TDI_REG_VOLT       3'h7

// ==========================================================================
// fields, limits and reset values (levels in 0.1 V units)
`define TDI_CFG_SENSE_BIT  0
`define TDI_CFG_AC_BIT     1
`define TDI_CFG_NUM_LSB    8
`define TDI_PICKUP_RST     16'h0370
`define TDI_DROPOUT_RST    16'h0258
`define TDI_PICKUP_MIN     16'h00A0
`define TDI_DROPOUT_MIN    16'h0064
`define TDI_LEVEL_MAX      16'h07D0
`define TDI_DELAY_MAX      21'h1B7740
`define TDI_MV_PER_DV      20'h00064
`define TDI_MV_PER_PCT     20'h0000A
`define TDI_CLEAR_CMD      32'h00000001

`endif

// ---- rtl/tdi_pkg.sv ----
// types shared by the threshold input bank modules
// assumes tdi_consts.svh is on the include path
package tdi_pkg;
  localparam int NUM_CH = 8;
  typedef logic [19:0] tdi_mv_t;
  typedef logic [15:0] tdi_dv_t;
  typedef logic [20:0] tdi_ms_t;
  typedef logic [31:0] tdi_word_t;
endpackage

// ---- rtl/tdi_channel.sv ----
// one input channel: hysteresis comparator, qualify delays, rising tally
// assumes a one-cycle scan pulse and a voltage sample on the same clock
`timescale 1ns/1ps
`include "tdi_consts.svh"
module tdi_channel (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             scan_in,
  input  wire tdi_pkg::tdi_mv_t volt_in,
  input  wire logic             sense_in,
  input  wire logic             ac_in,
  input  wire tdi_pkg::tdi_dv_t pickup_in,
  input  wire tdi_pkg::tdi_dv_t dropout_in,
  input  wire tdi_pkg::tdi_ms_t rise_in,
  input  wire tdi_pkg::tdi_ms_t fall_in,
  input  wire logic             clear_in,
  output logic                  state_out,
  output tdi_pkg::tdi_word_t    tally_out
);
  import tdi_pkg::*;

  // ========================================================================
  // comparator
  logic        energ_q;
  logic [21:0] elapsed_q;
  wire  [19:0] pick_mv = 20'(pickup_in) * `TDI_MV_PER_DV;
  wire  [19:0] drop_mv = ac_in ? 20'(pickup_in) * `TDI_MV_PER_PCT
                               : 20'(dropout_in) * `TDI_MV_PER_DV;
  // between the levels the old state holds
  wire energ_d = (volt_in > pick_mv) ? 1'b1 :
                 (volt_in < drop_mv) ? 1'b0 : energ_q;
  wire raw     = energ_d ^ sense_in;

  // ========================================================================
  // qualify delays, counted in whole scans of 5 ms
  wire [21:0] need_ms = raw ? {1'b0, rise_in}
                            : {1'b0, fall_in}
                              + (ac_in ? `TDI_AC_EXTRA_MS : 22'h000000);
  wire        differ  = raw != state_out;
  wire        fire    = differ && (elapsed_q >= need_ms);
  wire        rise    = scan_in && fire && raw;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      energ_q   <= 1'b0;
      elapsed_q <= 22'h000000;
      state_out <= 1'b0;
    end else if (scan_in) begin
      energ_q <= energ_d;
      if (!differ || fire) begin
        elapsed_q <= 22'h000000; // reverting cancels the pending change
      end else begin
        elapsed_q <= elapsed_q + `TDI_SCAN_STEP_MS;
      end
      if (fire) begin
        state_out <= raw;
      end
    end
  end

  // ========================================================================
  // tally; a rise in the clear cycle still counts
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tally_out <= 32'h00000000;
    end else if (rise) begin
      tally_out <= clear_in ? 32'h00000001 : tally_out + 32'h00000001;
    end else if (clear_in) begin
      tally_out <= 32'h00000000;
    end
  end
endmodule

// ---- sim/tdi_bank_sva.sv ----
// checker for the bank's bus answers, readback and scan-timed state changes
// assumes hready_in is tied to hreadyout_out
`timescale 1ns/1ps
module tdi_bank_sva #(
  parameter int unsigned SCAN_CYCLES = 20
) (
  input wire logic                   mclk_in,
  input wire logic                   rst_n_in,
  input wire logic                   hsel_in,
  input wire logic [31:0]            haddr_in,
  input wire logic [1:0]             htrans_in,
  input wire logic                   hwrite_in,
  input wire logic                   hready_in,
  input wire tdi_pkg::tdi_mv_t [7:0] volt_in,
  input wire logic                   hreadyout_out,
  input wire logic                   hresp_out,
  input wire tdi_pkg::tdi_word_t     hrdata_out,
  input wire logic [7:0]             state_out
);
  import tdi_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // helpers: own scan phase, loose by a few clocks on purpose
  logic [31:0] scan_q;
  logic [31:0] scan_d;
  logic        rd_w;
  logic [11:0] a_w;
  assign a_w    = haddr_in[11:0];
  assign rd_w   = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
  assign scan_d = (scan_q == SCAN_CYCLES - 1) ? 32'h0 : scan_q + 32'h1;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scan_q <= 32'h0;
    end else begin
      scan_q <= scan_d;
    end
  end
  // ==========================================================
  // assertions
  chk_bus_okay: assert property (hresp_out == 1'h0 && hreadyout_out == 1'h1)
    else $error("bus answer not okay");
  chk_scan_only: assert property ($changed(state_out) |-> scan_q <= 32'h3)
    else $error("state moved between scans");
  chk_rdata_hold: assert property ($changed(hrdata_out) |-> $past(rd_w))
    else $error("read data moved without read");
  chk_state_read: assert property (rd_w && a_w == 12'h004 |=>
    hrdata_out == {24'h0, $past(state_out)}) else $error("state readback wrong");
  chk_unmapped_zero: assert property (rd_w && a_w[11:8] == 4'h0 && a_w[7:2] > 6'h1 |=>
    hrdata_out == 32'h0) else $error("unmapped read not zero");
  chk_volt_read: assert property (rd_w && a_w[11:8] == 4'h1 && a_w[4:2] == 3'h7 |=>
    hrdata_out == {12'h0, $past(volt_in[a_w[7:5]])}) else $error("voltage readback wrong");
  chk_pickup_range: assert property (rd_w && a_w[11:8] == 4'h1 && a_w[4:2] == 3'h1 |=>
    hrdata_out inside {[32'hA0:32'h7D0]}) else $error("pickup out of range");
  chk_dropout_range: assert property (rd_w && a_w[11:8] == 4'h1 && a_w[4:2] == 3'h2 |=>
    hrdata_out inside {[32'h64:32'h7D0]}) else $error("dropout out of range");
endmodule

bind tdi_bank tdi_bank_sva #(.SCAN_CYCLES(SCAN_CYCLES)) tdi_bank_sva_i (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in), .volt_in(volt_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out),
  .state_out(state_out));

// ---- sim/tdi_field.sv ----
// field contacts: energising voltage on each of the eight inputs
// assumes the bench commands target levels in millivolts
`timescale 1ns/1ps
module tdi_field (
  input  wire logic                   mclk_in,
  input  wire tdi_pkg::tdi_mv_t [7:0] lvl_in,
  output tdi_pkg::tdi_mv_t [7:0]      volt_out
);
  import tdi_pkg::*;
  // ==========================================================
  // contacts settle one clock after a command, no bounce
  always_ff @(posedge mclk_in) begin
    volt_out <= lvl_in;
  end
endmodule

// ---- sim/tb_tdi_bank.sv ----
// self-checking bench for the eight-input threshold bank
// assumes a shortened scan of SC clocks; waits are counted in clocks, as whole scans give or take a few clocks
`timescale 1ns/1ps
module tb_tdi_bank;
  import tdi_pkg::*;
  localparam int SC = 20;
  logic          mclk, rst_n, hsel, hwrite;
  logic [31:0]   haddr, hwdata, rd;
  logic [1:0]    htrans;
  wire logic     hready;
  tdi_mv_t [7:0] lvl, volt;
  logic [7:0]    st;
  tdi_word_t     hrdata;
  logic          hresp;
  int            num_errors, samples_checked, cyc;
  tdi_bank #(.SCAN_CYCLES(SC)) tdi_bank_i (.mclk_in(mclk), .rst_n_in(rst_n), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .volt_in(volt), .hreadyout_out(hready),
    .hresp_out(hresp), .hrdata_out(hrdata), .state_out(st));
  tdi_field tdi_field_i (.mclk_in(mclk), .lvl_in(lvl), .volt_out(volt));
  // ==========================================================
  // tasks
  task automatic results();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'h1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  function automatic logic [11:0] ca(input int g, input int r);
    return 12'(12'h100 + g * 32 + r * 4);
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic sv(input int g, input tdi_mv_t v);
    @(posedge mclk);
    lvl[g] <= v;
  endtask
  // ==========================================================
  // clock and hang guard
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      results();
    end
  end
  // ==========================================================
  // sequence
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    lvl = '0;
    {num_errors, samples_checked, cyc} = '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    rc(ca(0, 1), 32'h370);
    rc(ca(0, 2), 32'h258);
    rc(ca(0, 3), 32'h0);
    rc(12'h0F0, 32'h0);
    bus(1'h1, 12'h000, 32'h8);
    for (int g = 0; g < 8; g++) begin
      rc(ca(g, 0), 32'(8 + g + 1) << 8);
    end
    // normal sense, then the hysteresis band must hold
    sv(0, 20'h186A0);
    wt(2 * SC + 3);
    chk({31'h0, st[0]}, 32'h1);
    rc(ca(0, 7), 32'h186A0);
    sv(0, 20'h11170);
    wt(2 * SC + 3);
    chk({31'h0, st[0]}, 32'h1);
    sv(0, 20'h0C350);
    wt(2 * SC + 3);
    chk({31'h0, st[0]}, 32'h0);
    rc(ca(0, 5), 32'h1);
    // inverted sense on one channel leaves its neighbour alone
    bus(1'h1, ca(1, 0), 32'h1);
    wt(2 * SC + 3);
    chk({30'h0, st[1:0]}, 32'h2);
    // rise delay of two scans, first a glitch that must be dropped
    bus(1'h1, ca(2, 3), 32'hA);
    sv(2, 20'h186A0);
    wt(SC);
    sv(2, 20'h0);
    wt(4 * SC);
    chk({31'h0, st[2]}, 32'h0);
    sv(2, 20'h186A0);
    wt(2 * SC - 2);
    chk({31'h0, st[2]}, 32'h0);
    wt(2 * SC + 5);
    chk({31'h0, st[2]}, 32'h1);
    // alternating mode: low dropout, fall delay plus the extra 30 ms
    bus(1'h1, ca(2, 4), 32'h5);
    bus(1'h1, ca(2, 0), 32'h2);
    sv(2, 20'h04E20);
    wt(3 * SC);
    chk({31'h0, st[2]}, 32'h1);
    sv(2, 20'h0);
    wt(7 * SC - 2);
    chk({31'h0, st[2]}, 32'h1);
    wt(2 * SC + 5);
    chk({31'h0, st[2]}, 32'h0);
    rc(12'h004, 32'h2);
    rc(ca(2, 5), 32'h1);
    bus(1'h1, ca(0, 6), 32'h1);
    rc(ca(0, 5), 32'h0);
    rc(ca(0, 6), 32'h0);
    results();
  end
endmodule
